// ==== rtl/spc_servo_pi.sv ====
/*
 * current and velocity pi loops, limit clamp, pwm modulator, parameter port and
 * analog position command scaling of a brushless servo drive.
 * assumes a single 250 MHz clock, synchronous inputs, and a terminal front end that
 * turns typed parameter commands into single-cycle read and write strobes.
 */
// What this block does
// - current output is a proportional plus an integral term of the current error.
// - at shift zero, gain codes 0 to 32767 span 0 to 100 percent.
// - gain codes are signed and accept values down to -32768.
// - shift 0 to 7 multiplies both gains by two to that power.
// - commanded voltage is compared with a modulator carrier to make the pwm.
// - commanded voltage is clamped between programmable positive and negative limits.
// - limits beyond the modulator range are cut to the modulator's own limits.
// - a query returns the modulator's internal limit value.
// - velocity loop is also pi with its own proportional and integral gains.
// - analog command scales linearly to a position target in degrees, revs or radians.
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_servo_pi
    import spc_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic [3:0]         param_index,
    input  wire logic [15:0]        param_wdata,
    input  wire logic               param_write,
    input  wire logic               param_read,
    output logic [15:0]             param_rdata_r,
    output logic                    param_rvalid_r,
    input  wire logic signed [15:0] current_error,
    input  wire logic signed [15:0] velocity_error,
    input  wire logic signed [15:0] analog_command,
    output logic signed [15:0]      commanded_voltage,
    output logic signed [15:0]      current_command,
    output logic                    pwm_out_r,
    output logic                    cycle_strobe_r,
    output logic signed [31:0]      position_target_r,
    output spc_unit_t               position_unit_r
);

    // parameter registers
    spc_gain_t          cur_gain_r;
    spc_gain_t          cur_gain_nxt;
    spc_gain_t          vel_gain_r;
    spc_gain_t          vel_gain_nxt;
    spc_limit_t         lim_r;
    spc_limit_t         lim_nxt;
    logic signed [15:0] pos_full_r;
    logic signed [15:0] pos_full_nxt;
    spc_unit_t          unit_nxt;
    logic [15:0]        rdata_nxt;

    always_comb
    begin
        cur_gain_nxt = cur_gain_r;
        vel_gain_nxt = vel_gain_r;
        lim_nxt      = lim_r;
        pos_full_nxt = pos_full_r;
        unit_nxt     = position_unit_r;
        if (param_write)
        begin
            unique case (param_index)
                `SPC_IDX_CUR_KP:    cur_gain_nxt.kp    = param_wdata;
                `SPC_IDX_CUR_KI:    cur_gain_nxt.ki    = param_wdata;
                `SPC_IDX_CUR_SHIFT: cur_gain_nxt.shift = param_wdata[2:0];
                `SPC_IDX_LIM_POS:   lim_nxt.hi         = param_wdata;
                `SPC_IDX_LIM_NEG:   lim_nxt.lo         = param_wdata;
                `SPC_IDX_VEL_KP:    vel_gain_nxt.kp    = param_wdata;
                `SPC_IDX_VEL_KI:    vel_gain_nxt.ki    = param_wdata;
                `SPC_IDX_POS_FULL:  pos_full_nxt       = param_wdata;
                `SPC_IDX_POS_UNIT:
                begin
                    // an unknown unit code is ignored so the target keeps a meaning
                    unique case (param_wdata[1:0])
                        2'h0:    unit_nxt = SPC_UNIT_DEG;
                        2'h1:    unit_nxt = SPC_UNIT_REV;
                        2'h2:    unit_nxt = SPC_UNIT_RAD;
                        default: unit_nxt = position_unit_r;
                    endcase
                end
                default:            ;
            endcase
        end
        rdata_nxt = param_rdata_r;
        if (param_read)
        begin
            unique case (param_index)
                `SPC_IDX_CUR_KP:    rdata_nxt = cur_gain_r.kp;
                `SPC_IDX_CUR_KI:    rdata_nxt = cur_gain_r.ki;
                `SPC_IDX_CUR_SHIFT: rdata_nxt = {13'h0000, cur_gain_r.shift};
                `SPC_IDX_LIM_POS:   rdata_nxt = lim_r.hi;
                `SPC_IDX_LIM_NEG:   rdata_nxt = lim_r.lo;
                `SPC_IDX_MOD_QUERY: rdata_nxt = `SPC_MOD_LIMIT;
                `SPC_IDX_VEL_KP:    rdata_nxt = vel_gain_r.kp;
                `SPC_IDX_VEL_KI:    rdata_nxt = vel_gain_r.ki;
                `SPC_IDX_POS_FULL:  rdata_nxt = pos_full_r;
                `SPC_IDX_POS_UNIT:  rdata_nxt = {14'h0000, position_unit_r};
                `SPC_IDX_CMD_VOLT:  rdata_nxt = commanded_voltage;
                default:            rdata_nxt = `SPC_RST_ZERO16;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cur_gain_r      <= '{`SPC_RST_GAIN, `SPC_RST_GAIN, `SPC_RST_SHIFT};
            vel_gain_r      <= '{`SPC_RST_GAIN, `SPC_RST_GAIN, `SPC_VEL_SHIFT};
            lim_r           <= '{`SPC_RST_LIMIT, `SPC_RST_LIMIT};
            pos_full_r      <= `SPC_RST_POS_FULL;
            position_unit_r <= SPC_UNIT_DEG;
            param_rdata_r   <= `SPC_RST_ZERO16;
            param_rvalid_r  <= 1'b0;
        end
        else
        begin
            cur_gain_r      <= cur_gain_nxt;
            vel_gain_r      <= vel_gain_nxt;
            lim_r           <= lim_nxt;
            pos_full_r      <= pos_full_nxt;
            position_unit_r <= unit_nxt;
            param_rdata_r   <= rdata_nxt;
            param_rvalid_r  <= param_read;
        end
    end

    // effective clamp: programmed current limits cut to the modulator range; velocity limits fixed
    spc_limit_t cur_lim_w;
    spc_limit_t vel_lim_w;

    always_comb
    begin
        cur_lim_w.hi = (lim_r.hi > `SPC_MOD_LIMIT)     ? `SPC_MOD_LIMIT     : lim_r.hi;
        cur_lim_w.lo = (lim_r.lo < `SPC_MOD_LIMIT_NEG) ? `SPC_MOD_LIMIT_NEG : lim_r.lo;
        vel_lim_w.hi = `SPC_VEL_LIM_POS;
        vel_lim_w.lo = `SPC_VEL_LIM_NEG;
    end

    // triangle carrier; the control cycle fires once per carrier period at the valley
    spc_carrier_t       dir_r;
    spc_carrier_t       dir_nxt;
    logic signed [15:0] carrier_r;
    logic signed [15:0] carrier_nxt;
    logic               pwm_nxt;
    logic               strobe_nxt;

    always_comb
    begin
        dir_nxt     = dir_r;
        carrier_nxt = carrier_r;
        strobe_nxt  = 1'b0;
        unique case (dir_r)
            SPC_CARRIER_UP:
            begin
                if (carrier_r >= `SPC_MOD_LIMIT)
                begin
                    dir_nxt     = SPC_CARRIER_DOWN;
                    carrier_nxt = carrier_r - 16'sh0001;
                end
                else
                    carrier_nxt = carrier_r + 16'sh0001;
            end
            SPC_CARRIER_DOWN:
            begin
                if (carrier_r <= `SPC_MOD_LIMIT_NEG)
                begin
                    dir_nxt     = SPC_CARRIER_UP;
                    carrier_nxt = carrier_r + 16'sh0001;
                    strobe_nxt  = 1'b1;
                end
                else
                    carrier_nxt = carrier_r - 16'sh0001;
            end
        endcase
        // a clamp at the negative modulator limit gives full off; at the positive limit the pwm is low for one clock per period
        pwm_nxt = (commanded_voltage > carrier_r);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            dir_r          <= SPC_CARRIER_UP;
            carrier_r      <= `SPC_RST_LIMIT;
            pwm_out_r      <= 1'b0;
            cycle_strobe_r <= 1'b0;
        end
        else
        begin
            dir_r          <= dir_nxt;
            carrier_r      <= carrier_nxt;
            pwm_out_r      <= pwm_nxt;
            cycle_strobe_r <= strobe_nxt;
        end
    end

    // position target: full-scale analog command maps to the programmed target
    logic signed [31:0] target_nxt;

    always_comb
    begin
        target_nxt = (32'(analog_command) * 32'(pos_full_r)) >>> `SPC_GAIN_FRAC;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            position_target_r <= 32'sh0000_0000;
        else
            position_target_r <= target_nxt;
    end

    spc_pi_core u_current_loop (
        .clock (clock),
        .reset (reset),
        .step  (cycle_strobe_r),
        .error (current_error),
        .gain  (cur_gain_r),
        .limit (cur_lim_w),
        .out_r (commanded_voltage)
    );

    // same structure, its own gains, no shift
    spc_pi_core u_velocity_loop (
        .clock (clock),
        .reset (reset),
        .step  (cycle_strobe_r),
        .error (velocity_error),
        .gain  (vel_gain_r),
        .limit (vel_lim_w),
        .out_r (current_command)
    );

endmodule : spc_servo_pi

// ==== rtl/spc_map.svh ====
/*
 * register indices, reset values, scaling and timing constants of the current loop block.
 * assumes inclusion by bare name from the rtl folder.
 */
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// parameter indices on the terminal port
`define SPC_IDX_CUR_KP      4'h0
`define SPC_IDX_CUR_KI      4'h1
`define SPC_IDX_CUR_SHIFT   4'h2
`define SPC_IDX_LIM_POS     4'h3
`define SPC_IDX_LIM_NEG     4'h4
`define SPC_IDX_MOD_QUERY   4'h5
`define SPC_IDX_VEL_KP      4'h6
`define SPC_IDX_VEL_KI      4'h7
`define SPC_IDX_POS_FULL    4'h8
`define SPC_IDX_POS_UNIT    4'h9
`define SPC_IDX_CMD_VOLT    4'hA

// reset values
`define SPC_RST_GAIN        16'sh0000
`define SPC_RST_SHIFT       3'h0
`define SPC_RST_LIMIT       16'sh0000
`define SPC_RST_POS_FULL    16'sh0000
`define SPC_RST_ZERO16      16'h0000

// gain code 32767 is just below unity, so products drop 15 fraction bits
`define SPC_GAIN_FRAC       15
// numerical limit of the modulating signal, reported on query
`define SPC_MOD_LIMIT       16'sh0282
`define SPC_MOD_LIMIT_NEG   16'shFD7E
// the velocity output spans the signed range except -32768
`define SPC_VEL_LIM_POS     16'sh7FFF
`define SPC_VEL_LIM_NEG     16'sh8001
`define SPC_VEL_SHIFT       3'h0

`endif

// ==== rtl/spc_pkg.sv ====
/*
 * types shared by the current loop block and its pi core.
 * assumes spc_map.svh is compiled before any user of these types.
 */
package spc_pkg;

    typedef struct packed {
        logic signed [15:0] kp;
        logic signed [15:0] ki;
        logic        [2:0]  shift;
    } spc_gain_t;

    typedef struct packed {
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } spc_limit_t;

    typedef enum logic [1:0] {
        SPC_UNIT_DEG,
        SPC_UNIT_REV,
        SPC_UNIT_RAD
    } spc_unit_t;

    typedef enum logic {
        SPC_CARRIER_UP,
        SPC_CARRIER_DOWN
    } spc_carrier_t;

endpackage : spc_pkg

// ==== rtl/spc_pi_core.sv ====
/*
 * one proportional-integral stage with power-of-two gain scaling and output clamp.
 * assumes step is a one-cycle pulse once per control cycle and limit.hi >= limit.lo.
 */
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_pi_core
    import spc_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               step,
    input  wire logic signed [15:0] error,
    input  wire spc_gain_t          gain,
    input  wire spc_limit_t         limit,
    output logic signed [15:0]      out_r
);

    logic signed [39:0] prop_w;
    logic signed [39:0] integ_w;
    logic signed [39:0] acc_sum_w;
    logic signed [15:0] acc_r;
    logic signed [15:0] acc_nxt;
    logic signed [15:0] out_nxt;

    function automatic logic signed [15:0] spc_sat(
        input logic signed [39:0] x,
        input logic signed [15:0] hi,
        input logic signed [15:0] lo
    );
        if (x > 40'(hi))
            return hi;
        else if (x < 40'(lo))
            return lo;
        else
            return x[15:0];
    endfunction : spc_sat

    always_comb
    begin
        // both terms work on the same error sample
        // negative codes are legal signed operands
        // shift multiplies both gains by 2**shift
        // code 32767 at shift 0 is near unity
        prop_w    = ((40'(error) * 40'(gain.kp)) <<< gain.shift) >>> `SPC_GAIN_FRAC;
        integ_w   = ((40'(error) * 40'(gain.ki)) <<< gain.shift) >>> `SPC_GAIN_FRAC;
        acc_sum_w = 40'(acc_r) + integ_w;
        acc_nxt   = acc_r;
        out_nxt   = out_r;
        if (step)
        begin
            // the accumulator saturates at the output limits, so no windup
            acc_nxt   = spc_sat(acc_sum_w, limit.hi, limit.lo);
            out_nxt   = spc_sat(prop_w + 40'(acc_nxt), limit.hi, limit.lo);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            acc_r <= `SPC_RST_LIMIT;
            out_r <= `SPC_RST_LIMIT;
        end
        else
        begin
            acc_r <= acc_nxt;
            out_r <= out_nxt;
        end
    end

endmodule : spc_pi_core

// ==== verification/spc_servo_pi_checker.sv ====
/*
 * port assertions of the current loop block.
 * assumes a bind onto spc_servo_pi with its single clock.
 */
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_chk (
    input wire logic               clock,
    input wire logic               reset,
    input wire logic [3:0]         param_index,
    input wire logic               param_read,
    input wire logic [15:0]        param_rdata_r,
    input wire logic               param_rvalid_r,
    input wire logic signed [15:0] commanded_voltage,
    input wire logic signed [15:0] current_command,
    input wire logic               pwm_out_r,
    input wire logic               cycle_strobe_r
);
    logic [11:0] gap_r, gap_nxt;
    logic        seen_r, seen_nxt;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // the first period after reset is short, so spacing is judged from the second strobe
    always_comb
    begin
        gap_nxt  = cycle_strobe_r ? 12'h000 : gap_r + 12'h001;
        seen_nxt = seen_r | cycle_strobe_r;
    end
    always_ff @(posedge clock or posedge reset)
        if (reset) {gap_r, seen_r} <= 13'h0000;
        else {gap_r, seen_r} <= {gap_nxt, seen_nxt};

    property p_rv; param_read |=> param_rvalid_r; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_rv_src; param_rvalid_r |-> $past(param_read); endproperty
    a_rv_src: assert property (p_rv_src) else $error("stray read answer");
    property p_query; param_read && param_index == 4'h5 |=> param_rdata_r == `SPC_MOD_LIMIT;
    endproperty
    a_query: assert property (p_query) else $error("bad modulator limit");
    property p_top; commanded_voltage <= `SPC_MOD_LIMIT; endproperty
    a_top: assert property (p_top) else $error("voltage above modulator");
    property p_bot; commanded_voltage >= `SPC_MOD_LIMIT_NEG; endproperty
    a_bot: assert property (p_bot) else $error("voltage below modulator");
    property p_stand; !cycle_strobe_r |=> $stable(commanded_voltage); endproperty
    a_stand: assert property (p_stand) else $error("voltage moved off cycle");
    property p_period; cycle_strobe_r && seen_r |-> gap_r == 12'hA07; endproperty
    a_period: assert property (p_period) else $error("carrier period wrong");
    property p_pwm_low; $past(commanded_voltage) == `SPC_MOD_LIMIT_NEG |-> !pwm_out_r;
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("pwm high at floor");
    property p_vel; current_command != 16'sh8000; endproperty
    a_vel: assert property (p_vel) else $error("velocity out of range");

    c_strobe: cover property (cycle_strobe_r);
    c_top: cover property (commanded_voltage == `SPC_MOD_LIMIT);
    c_query: cover property (param_read && param_index == 4'h5);
endmodule : spc_chk

bind spc_servo_pi spc_chk u_chk (.clock, .reset, .param_index, .param_read, .param_rdata_r,
    .param_rvalid_r, .commanded_voltage, .current_command, .pwm_out_r, .cycle_strobe_r);

// ==== verification/spc_stage_model.sv ====
/*
 * power stage model: counts pwm high clocks over each carrier period.
 * assumes strobe pulses once per carrier period.
 */
`timescale 1ns/100ps

module spc_stage_model (
    input wire logic    clock,
    input wire logic    reset,
    input wire logic    pwm,
    input wire logic    strobe,
    output logic [11:0] duty_r
);
    logic [11:0] on_r, on_nxt, duty_nxt;

    // the bridge averages its input, so only the on-time per period matters
    always_comb
    begin
        on_nxt   = (strobe ? 12'h000 : on_r) + {11'h000, pwm};
        duty_nxt = strobe ? on_r : duty_r;
    end
    always_ff @(posedge clock or posedge reset)
        if (reset) {on_r, duty_r} <= 24'h00_0000;
        else {on_r, duty_r} <= {on_nxt, duty_nxt};
endmodule : spc_stage_model

// ==== verification/spc_servo_pi_tb.sv ====
/*
 * self-checking bench of the current loop block with a power stage model.
 * assumes the rtl folder on the include path.
 */
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_servo_pi_tb
    import spc_pkg::*;
;
    logic               clock = 1'b0, reset = 1'b1, param_write = 1'b0, param_read = 1'b0;
    logic [3:0]         param_index = 4'h0;
    logic [15:0]        param_wdata = 16'h0000, param_rdata_r;
    logic signed [15:0] current_error = 16'sh0000, velocity_error = 16'sh0000;
    logic signed [15:0] analog_command = 16'sh0000, commanded_voltage, current_command;
    logic               param_rvalid_r, pwm_out_r, cycle_strobe_r, dv = 1'b0, stb_d = 1'b0;
    logic signed [31:0] position_target_r, r;
    spc_unit_t          position_unit_r;
    logic [11:0]        duty;
    logic [15:0]        rd_q[$], cv_q[$], cc_q[$];
    logic [33:0]        pt_q[$], pt;
    logic [1:0]         ue = 2'h0;
    logic [15:0]        iv[5] = '{16'h8000, 16'h7FFF, 16'h0007, 16'h7FFF, 16'h8001};
    longint             hi = 0, lo = 0, iacc = 0, prev_v = 0, vkp = 0, pfull = 0;
    int                 seed = 68, fails = 0, checked = 0;

    always #2 clock = ~clock;

    spc_servo_pi uut (.clock, .reset, .param_index, .param_wdata, .param_write, .param_read,
        .param_rdata_r, .param_rvalid_r, .current_error, .velocity_error, .analog_command,
        .commanded_voltage, .current_command, .pwm_out_r, .cycle_strobe_r,
        .position_target_r, .position_unit_r);
    spc_stage_model u_stage (.clock, .reset, .pwm(pwm_out_r), .strobe(cycle_strobe_r),
        .duty_r(duty));

    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_wide(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_wide

    // carrier values below v: once for the floor, twice for each inner step
    task automatic chk_duty(input longint v, input logic [11:0] g);
        longint d;
        d = g;
        checked++;
        if ((^g === 1'bx) || d > 2 * v + 1287 || d + 4 < 2 * v + 1283)
        begin
            fails++;
            $display("wrong value duty expected %0d seen %0d", 2 * v + 1283, d);
        end
    endtask : chk_duty

    task automatic wr(input logic [3:0] i, input logic [15:0] d);
        @(negedge clock);
        {param_index, param_wdata, param_write} = {i, d, 1'b1};
        @(negedge clock);
        param_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] i, input logic [15:0] e);
        @(negedge clock);
        {param_index, param_read} = {i, 1'b1};
        rd_q.push_back(e);
        @(negedge clock);
        param_read = 1'b0;
    endtask : rd

    function automatic longint sat(input longint x);
        return x > hi ? hi : (x < lo ? lo : x);
    endfunction : sat

    task automatic lim(input longint p, input longint n);
        wr(4'h3, 16'(p));
        wr(4'h4, 16'(n));
        hi = p < `SPC_MOD_LIMIT ? p : `SPC_MOD_LIMIT;
        lo = n > `SPC_MOD_LIMIT_NEG ? n : `SPC_MOD_LIMIT_NEG;
    endtask : lim

    task automatic step(input longint e, input longint kp, input longint ki, input int sh);
        int n;
        longint ve;
        wr(4'h0, 16'(kp));
        wr(4'h1, 16'(ki));
        wr(4'h2, 16'(sh));
        current_error = 16'(e);
        velocity_error = 16'($random(seed));
        analog_command = 16'($random(seed));
        iacc = sat(iacc + (((e * ki) <<< sh) >>> 15));
        cv_q.push_back(16'(sat((((e * kp) <<< sh) >>> 15) + iacc)));
        // velocity loop: shift fixed at zero, no integral gain written
        ve = (velocity_error * vkp) >>> 15;
        if (ve > `SPC_VEL_LIM_POS)
            ve = `SPC_VEL_LIM_POS;
        else if (ve < `SPC_VEL_LIM_NEG)
            ve = `SPC_VEL_LIM_NEG;
        cc_q.push_back(16'(ve));
        pt_q.push_back({ue, 32'((analog_command * pfull) >>> 15)});
        for (n = 0; n < 6000 && cv_q.size() > 0; n++)
            @(negedge clock);
        if (cv_q.size() > 0)
        begin
            fails++;
            finish_test();
        end
    endtask : step

    always @(negedge clock)
    begin
        if (param_rvalid_r === 1'b1 && rd_q.size() > 0)
            chk("rdata", rd_q.pop_front(), param_rdata_r);
        if (stb_d && cv_q.size() > 0)
        begin
            if (dv)
                chk_duty(prev_v, duty);
            chk("voltage", cv_q.pop_front(), commanded_voltage);
            chk("current_command", cc_q.pop_front(), current_command);
            pt = pt_q.pop_front();
            chk_wide("position_target", pt[31:0], position_target_r);
            chk("position_unit", 16'(pt[33:32]), 16'(position_unit_r));
            prev_v = commanded_voltage;
            dv = 1'b1;
        end
        else if (stb_d)
            dv = 1'b0;
        stb_d = cycle_strobe_r === 1'b1;
    end

    initial
    begin
        repeat (5) @(negedge clock);
        reset = 1'b0;
        rd(4'h5, `SPC_MOD_LIMIT);
        wr(4'h5, 16'h1234);
        rd(4'h5, `SPC_MOD_LIMIT);
        rd(4'hF, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            rd(4'(i), 16'h0000);
            wr(4'(i), iv[i]);
            rd(4'(i), iv[i]);
        end
        lim(32767, -32767);
        wr(4'h6, 16'h7FFF);
        vkp = 32767;
        rd(4'h6, 16'h7FFF);
        rd(4'h7, 16'h0000);
        wr(4'h8, 16'h01F4);
        pfull = 500;
        rd(4'h8, 16'h01F4);
        wr(4'h9, 16'h0002);
        ue = 2'h2;
        wr(4'h9, 16'h0003);
        rd(4'h9, 16'h0002);
        for (int s = 0; s < 8; s++)
            step(100, 10000, 0, s);
        step(500, 32767, 0, 0);
        rd(4'hA, 16'h01F3);
        wr(4'hA, 16'h1234);
        rd(4'hA, 16'h01F3);
        step(700, -32768, 0, 0);
        repeat (5)
            step(300, 0, 16384, 0);
        step(-300, 0, 16384, 0);
        repeat (3)
        begin
            r = $random(seed);
            step(r % 2000, $signed(r[15:0]), $signed(r[31:28]), int'(r[17:16]));
        end
        reset = 1'b1;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        iacc = 0;
        vkp = 0;
        pfull = 0;
        ue = 2'h0;
        dv = 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h9, 16'h0000);
        wr(4'h9, 16'h0001);
        ue = 2'h1;
        lim(100, -50);
        step(1000, 32767, 0, 0);
        step(-1000, 32767, 0, 0);
        finish_test();
    end
endmodule : spc_servo_pi_tb
